/* dv/oct_fault_trim_tb.sv */
// Purpose: self-checking bench for oct_fault_trim
// Assumes: all drives and samples at 10 ns after the rising edge
// Notes: fault timing is counted in whole clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "oct_consts.svh"
module oct_fault_trim_tb;
  logic clk = 1'h0, rst = 1'h1, bidir = 1'h1, ove = 1'h0, ot = 1'h0, tv = 1'h0;
  logic req, wr, nv, via, ack, refuse, stb, nsel, inv, fn, opa, ona, rdy;
  logic [1:0] sel;
  logic [25:0] nv0, nv1 = 26'h0, wd, rd, nvd, d;
  logic [11:0] pex = 12'h0, nex = 12'h0, ts = 12'h0, gain, zero, tc;
  int mismatches = 0, checked = 0, seed = 89, i, q, c, t, e;
  always #50 clk = ~clk;
  oct_host_model oct_host_model_inst (.CLK(clk), .ACC_REQ(req), .ACC_WRITE(wr), .ACC_NV(nv),
    .ACC_SEL(sel), .ACC_VIA_OUT(via), .ACC_WDATA(wd));
  oct_fault_trim oct_fault_trim_inst (.CLK(clk), .RST(rst), .NV_WORD0(nv0), .NV_WORD1(nv1),
    .VARIANT_BIDIR(bidir), .ACC_REQ(req), .ACC_WRITE(wr), .ACC_NV(nv), .ACC_SEL(sel),
    .ACC_VIA_OUT(via), .OVERVOLTAGE_ENTRY(ove), .ACC_WDATA(wd), .POS_EXCURSION(pex),
    .NEG_EXCURSION(nex), .OT_DETECT(ot), .TEMP_SAMPLE(ts), .TEMP_SAMPLE_VALID(tv),
    .ACC_ACK(ack), .ACC_REFUSE(refuse), .ACC_RDATA(rd), .NV_WR_STB(stb), .NV_WR_SEL(nsel),
    .NV_WR_DATA(nvd), .GAIN_TRIM(gain), .ZERO_LEVEL_TRIM(zero), .OUTPUT_SENSE_INVERT(inv),
    .FAULT_N(fn), .OC_POS_ACTIVE(opa), .OC_NEG_ACTIVE(ona), .TEMP_CODE(tc), .READY(rdy));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic chk(input string s, input logic [25:0] x, input logic [25:0] g);
    checked++;
    if (x !== g) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // bounded wait for the startup load to finish
  task automatic wait_ready;
    for (i = 0; i < 10 && rdy !== 1'h1; i++) tick(1);
    if (rdy !== 1'h1) begin
      mismatches++;
      stop_test();
    end
  endtask : wait_ready
  task automatic wsh(input logic [1:0] s, input logic [25:0] x);
    oct_host_model_inst.acc(1'h1, 1'h0, s, 1'h0, x);
    tick(1);
  endtask : wsh
  function automatic int qual_cycles(input int k);
    case (k)
      0: return `OCT_CYC(`OCT_QUAL0_NS);
      1: return `OCT_CYC(`OCT_QUAL1_NS);
      2: return `OCT_CYC(`OCT_QUAL2_NS);
      3: return `OCT_CYC(`OCT_QUAL3_NS);
      4: return `OCT_CYC(`OCT_QUAL4_NS);
      5: return `OCT_CYC(`OCT_QUAL5_NS);
      6: return `OCT_CYC(`OCT_QUAL6_NS);
      default: return `OCT_CYC(`OCT_QUAL7_NS);
    endcase
  endfunction : qual_cycles
  // margin is capped so release never sits under 25 percent of full scale
  function automatic int margin(input int k, input int trip);
    int m;
    m = (k == 0) ? `OCT_HYST0 : (k == 1) ? `OCT_HYST1 : (k == 2) ? `OCT_HYST2 : `OCT_HYST3;
    return (m > trip - `OCT_HYST_FLOOR) ? trip - `OCT_HYST_FLOOR : m;
  endfunction : margin
  // reader side conversion; only codes on whole degrees compare exactly
  function automatic real celsius(input int k);
    return (k - 2200) / 13.5 + 25.0;
  endfunction : celsius
  task automatic set_ex(input logic neg, input int v);
    if (neg) nex = v[11:0];
    else pex = v[11:0];
  endtask : set_ex
  task automatic trip(input logic neg, input int n, input int lvl, input int m);
    set_ex(neg, lvl + 1);
    tick(n - 1);
    chk("fault before qualifier", 26'h1, fn);
    tick(1);
    chk("fault after qualifier", 26'h0, fn);
    chk("direction active", 26'h1, neg ? ona : opa);
    set_ex(neg, lvl - m);
    tick(12);
    chk("fault at release level", 26'h0, fn);
    set_ex(neg, lvl - m - 1);
    tick(`OCT_CYC(`OCT_CLR_NS) - 1);
    chk("fault before clear time", 26'h0, fn);
    tick(1);
    chk("fault released", 26'h1, fn);
    // back to rest so the next trip level cannot be crossed by a stale excursion
    set_ex(neg, 0);
  endtask : trip
  initial begin
    nv0 = 26'($random(seed));
    // trip hold left clear so the overtemperature release after power cycling works
    nv1 = 26'($random(seed)) & 26'h37FFFFF;
    tick(16);
    rst = 1'h0;
    wait_ready();
    chk("sense invert", 26'(!nv0[21]), 26'(inv));
    chk("idle fault", 26'h1, fn);
    oct_host_model_inst.acc(1'h0, 1'h0, 2'h0, 1'h0, 26'h0);
    chk("shadow word0", nv0, rd);
    oct_host_model_inst.acc(1'h0, 1'h0, 2'h1, 1'h0, 26'h0);
    chk("shadow word1", nv1, rd);
    for (q = 0; q < 4; q++) begin
      d = 26'($random(seed)) & 26'h0FFFFFF;
      wsh(2'h0, d);
      chk("gain trim", 26'({{3{d[8]}}, d[8:0]}), 26'(gain));
      chk("zero trim", 26'({{3{d[17]}}, d[17:9]}), 26'(zero));
      chk("sense invert", 26'(!d[21]), 26'(inv));
    end
    for (q = 0; q < 32; q++) begin
      wsh(2'h0, {q[0], q[1], 24'h200000});
      ove = q[4];
      d = 26'($random(seed));
      e = (q[3] && (!q[4] || q[1])) || (q[2] && q[0]);
      oct_host_model_inst.acc(q[2], 1'h1, 2'h1, q[3], d);
      chk("lock refuse", 26'(e), 26'(refuse));
      chk("access ack", 26'(!e), 26'(ack));
      chk("eeprom write", 26'(q[2] && !e), 26'(stb));
      if (q[2] && !e) chk("eeprom data", d, nvd);
      if (q[2] && !e) chk("eeprom word", 26'h1, 26'(nsel));
      if (!q[2] && !e) chk("eeprom read", nv1, rd);
    end
    ts = 12'($random(seed));
    tv = 1'h1;
    tick(1);
    tv = 1'h0;
    tick(1);
    chk("temp code", 26'(ts), 26'(tc));
    oct_host_model_inst.acc(1'h0, 1'h0, 2'h2, 1'h0, 26'h0);
    chk("temp read", {14'h0, ts}, rd);
    ts = 12'h898;
    tv = 1'h1;
    tick(1);
    tv = 1'h0;
    tick(1);
    chk("celsius at reference", 26'h19, 26'($rtoi(celsius(tc))));
    for (q = 2; q < 4; q++) begin
      oct_host_model_inst.acc(1'h1, 1'h0, q[1:0], 1'h0, 26'h0);
      chk("read only write", 26'h1, 26'(refuse));
      chk("read only write ack", 26'h0, 26'(ack));
    end
    oct_host_model_inst.acc(1'h0, 1'h0, 2'h3, 1'h0, 26'h0);
    chk("spare read", 26'h0, rd);
    for (q = 0; q < 8; q++) begin
      c = (q == 2 || q == 3) ? 0 : ($random(seed) & 127);
      t = `OCT_TRIP_BASE + c * `OCT_TRIP_STEP;
      wsh(2'h1, {q[1:0], 3'h0, q[2:0], 4'h0, c[6:0], c[6:0]});
      trip(q[0], qual_cycles(q), t, margin(q % 4, t));
    end
    wsh(2'h1, {2'h0, 1'h0, 1'h1, 1'h1, 21'h0});
    pex = 12'h3E8;
    nex = 12'h3E8;
    tick(40);
    chk("disabled trips", 26'h1, fn);
    chk("disabled negative", 26'h0, 26'(ona));
    wsh(2'h1, {2'h0, 1'h1, 23'h0});
    tick(qual_cycles(0));
    chk("held fault", 26'h0, fn);
    pex = 12'h0;
    nex = 12'h0;
    tick(40);
    chk("held after release", 26'h0, fn);
    rst = 1'h1;
    bidir = 1'h0;
    tick(2);
    chk("fault after power cycle", 26'h1, fn);
    rst = 1'h0;
    wait_ready();
    nex = 12'h3E8;
    tick(40);
    chk("unidirectional negative", 26'h1, fn);
    chk("unidirectional active", 26'h0, 26'(ona));
    ot = 1'h1;
    tick(1);
    chk("overtemperature fault", 26'h0, fn);
    ot = 1'h0;
    tick(3);
    chk("no fault left", 26'h1, fn);
    stop_test();
  end
endmodule : oct_fault_trim_tb
`default_nettype wire

/* dv/oct_host_model.sv */
// Purpose: programmer side of the overcurrent fault and trim block
// Assumes: one request in flight, answer one cycle after it is taken
// Notes: released write data is inverted so a stale word never looks valid
`timescale 1ns/1ps
`default_nettype none
module oct_host_model (
  input wire logic CLK,
  output logic ACC_REQ,
  output logic ACC_WRITE,
  output logic ACC_NV,
  output logic [1:0] ACC_SEL,
  output logic ACC_VIA_OUT,
  output logic [25:0] ACC_WDATA
);
  initial begin
    ACC_REQ = 1'h0;
    ACC_WRITE = 1'h0;
    ACC_NV = 1'h0;
    ACC_SEL = 2'h0;
    ACC_VIA_OUT = 1'h0;
    ACC_WDATA = 26'h0;
  end
  // callers program the gain trim and the zero level together in one word 0 write
  task automatic acc(input logic w, input logic n, input logic [1:0] s, input logic v,
                     input logic [25:0] d);
    @(posedge CLK);
    #10;
    ACC_REQ = 1'h1;
    ACC_WRITE = w;
    ACC_NV = n;
    ACC_SEL = s;
    ACC_VIA_OUT = v;
    ACC_WDATA = d;
    @(posedge CLK);
    #10;
    ACC_REQ = 1'h0;
    ACC_WDATA = ~d;
  endtask : acc
endmodule : oct_host_model
`default_nettype wire

/* logic/oct_consts.svh */
// Purpose: constants for the overcurrent fault and trim logic
// Assumes: 10 MHz clock, levels in tenths of a percent of full scale
// Notes: definitions only
`ifndef OCT_CONSTS_SVH
`define OCT_CONSTS_SVH
`define OCT_CLK_NS 100
`define OCT_CYC(ns) (((ns) + `OCT_CLK_NS - 1) / `OCT_CLK_NS)
`define OCT_WORD_W 26
// configuration word 0 layout
`define OCT_WLOCK_BIT 25
`define OCT_COMM_BIT 24
`define OCT_POL_BIT 21
`define OCT_ZERO_MSB 17
`define OCT_ZERO_LSB 9
`define OCT_GAIN_MSB 8
`define OCT_GAIN_LSB 0
// configuration word 1 layout
`define OCT_HYST_MSB 25
`define OCT_HYST_LSB 24
`define OCT_HOLD_BIT 23
`define OCT_PDIS_BIT 22
`define OCT_NDIS_BIT 21
`define OCT_QUAL_MSB 20
`define OCT_QUAL_LSB 18
`define OCT_NEG_MSB 13
`define OCT_NEG_LSB 7
`define OCT_POS_MSB 6
`define OCT_POS_LSB 0
// reset values: polarity 1, trip hold 0
`define OCT_CFG0_RST 26'h0200000
`define OCT_CFG1_RST 26'h0000000
// access selectors
`define OCT_SEL_CFG0 2'h0
`define OCT_SEL_CFG1 2'h1
`define OCT_SEL_TEMP 2'h2
// trip level = base + code * step, tenths of a percent
`define OCT_TRIP_BASE 12'h1F4
`define OCT_TRIP_STEP 12'h010
`define OCT_HYST_FLOOR 12'h0FA
`define OCT_HYST0 12'h06E
`define OCT_HYST1 12'h0DC
`define OCT_HYST2 12'h1A4
`define OCT_HYST3 12'h2EE
// qualifier delays in ns
`define OCT_QUAL0_NS 2300
`define OCT_QUAL1_NS 2900
`define OCT_QUAL2_NS 5000
`define OCT_QUAL3_NS 7600
`define OCT_QUAL4_NS 10100
`define OCT_QUAL5_NS 12600
`define OCT_QUAL6_NS 15300
`define OCT_QUAL7_NS 17900
// fault clear time in ns
`define OCT_CLR_NS 1000
`endif

/* logic/oct_fault_trim.sv */
// Purpose: lock policy, signed trims, polarity, overcurrent trip and release
// Assumes: excursions arrive as magnitudes in tenths of a percent of full scale
// Notes: RST stands for power cycling; it is the only way out of a held fault
`timescale 1ns/1ps
`default_nettype none
`include "oct_consts.svh"
module oct_fault_trim (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [`OCT_WORD_W-1:0] NV_WORD0,
  input wire logic [`OCT_WORD_W-1:0] NV_WORD1,
  input wire logic VARIANT_BIDIR,
  input wire logic ACC_REQ,
  input wire logic ACC_WRITE,
  input wire logic ACC_NV,
  input wire logic [1:0] ACC_SEL,
  input wire logic ACC_VIA_OUT,
  input wire logic OVERVOLTAGE_ENTRY,
  input wire logic [`OCT_WORD_W-1:0] ACC_WDATA,
  input wire logic [11:0] POS_EXCURSION,
  input wire logic [11:0] NEG_EXCURSION,
  input wire logic OT_DETECT,
  input wire logic [11:0] TEMP_SAMPLE,
  input wire logic TEMP_SAMPLE_VALID,
  output logic ACC_ACK,
  output logic ACC_REFUSE,
  output logic [`OCT_WORD_W-1:0] ACC_RDATA,
  output logic NV_WR_STB,
  output logic NV_WR_SEL,
  output logic [`OCT_WORD_W-1:0] NV_WR_DATA,
  output logic [11:0] GAIN_TRIM,
  output logic [11:0] ZERO_LEVEL_TRIM,
  output logic OUTPUT_SENSE_INVERT,
  output logic FAULT_N,
  output logic OC_POS_ACTIVE,
  output logic OC_NEG_ACTIVE,
  output logic [11:0] TEMP_CODE,
  output logic READY
);
  localparam logic [7:0] CLR_CYC = 8'(`OCT_CYC(`OCT_CLR_NS));
  oct_pkg::oct_state_t s_q;
  oct_pkg::oct_state_t s_d;
  logic wlock;
  logic comm_block;
  logic trip_hold;
  logic [1:0] trip_dis;
  logic [1:0] above;
  logic [1:0] below_rel;
  logic [1:0][11:0] trip_lvl;
  logic [1:0][11:0] hyst_eff;
  logic [1:0][11:0] exc;
  logic [11:0] hyst_raw;
  logic [7:0] qual_cyc;
  logic path_ok;

  assign wlock = s_q.cfg0[`OCT_WLOCK_BIT];
  assign comm_block = s_q.cfg0[`OCT_COMM_BIT];
  assign trip_hold = s_q.cfg1[`OCT_HOLD_BIT];
  assign exc[0] = POS_EXCURSION;
  assign exc[1] = NEG_EXCURSION;
  // negative side is dead on unidirectional parts
  assign trip_dis[0] = s_q.cfg1[`OCT_PDIS_BIT];
  assign trip_dis[1] = s_q.cfg1[`OCT_NDIS_BIT] | ~s_q.bidir;
  // the output pin path only exists after overvoltage entry
  assign path_ok = ~ACC_VIA_OUT | (OVERVOLTAGE_ENTRY & ~comm_block);

  always_comb begin
    case (s_q.cfg1[`OCT_HYST_MSB:`OCT_HYST_LSB])
      2'h0: hyst_raw = `OCT_HYST0;
      2'h1: hyst_raw = `OCT_HYST1;
      2'h2: hyst_raw = `OCT_HYST2;
      default: hyst_raw = `OCT_HYST3;
    endcase
  end

  always_comb begin
    case (s_q.cfg1[`OCT_QUAL_MSB:`OCT_QUAL_LSB])
      3'h0: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL0_NS));
      3'h1: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL1_NS));
      3'h2: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL2_NS));
      3'h3: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL3_NS));
      3'h4: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL4_NS));
      3'h5: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL5_NS));
      3'h6: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL6_NS));
      default: qual_cyc = 8'(`OCT_CYC(`OCT_QUAL7_NS));
    endcase
  end

  // per-direction trip level, clamped hysteresis and comparisons
  for (genvar i = 0; i < 2; i++) begin : g_dir
    logic [6:0] code;
    assign code = (i == 0) ? s_q.cfg1[`OCT_POS_MSB:`OCT_POS_LSB]
                           : s_q.cfg1[`OCT_NEG_MSB:`OCT_NEG_LSB];
    assign trip_lvl[i] = `OCT_TRIP_BASE + 12'(code * `OCT_TRIP_STEP);
    // trip never below 50 percent, so the subtraction cannot wrap
    assign hyst_eff[i] = (hyst_raw > trip_lvl[i] - `OCT_HYST_FLOOR)
                         ? trip_lvl[i] - `OCT_HYST_FLOOR : hyst_raw;
    assign above[i] = exc[i] > trip_lvl[i];
    assign below_rel[i] = exc[i] < trip_lvl[i] - hyst_eff[i];
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.refuse = 1'b0;
    s_d.nv_stb = 1'b0;
    if (s_q.phase == oct_pkg::PH_LOAD) begin
      // nonvolatile words become the governing shadow copies
      s_d.cfg0 = NV_WORD0;
      s_d.cfg1 = NV_WORD1;
      s_d.bidir = VARIANT_BIDIR;
      s_d.phase = oct_pkg::PH_RUN;
    end else if (ACC_REQ) begin
      if (!path_ok || (ACC_WRITE && ACC_NV && wlock)) begin
        s_d.refuse = 1'b1;
      end else if (ACC_WRITE && ACC_SEL[1] == 1'b0) begin
        s_d.ack = 1'b1;
        if (ACC_NV) begin
          s_d.nv_stb = 1'b1;
          s_d.nv_sel = ACC_SEL[0];
          s_d.nv_data = ACC_WDATA;
        end else if (ACC_SEL == `OCT_SEL_CFG0) begin
          s_d.cfg0 = ACC_WDATA;
        end else begin
          s_d.cfg1 = ACC_WDATA;
        end
      end else if (ACC_WRITE) begin
        s_d.refuse = 1'b1;
      end else begin
        s_d.ack = 1'b1;
        if (ACC_SEL == `OCT_SEL_TEMP) begin
          s_d.rdata = {14'h0000, s_q.temp};
        end else if (ACC_SEL == `OCT_SEL_CFG0) begin
          s_d.rdata = ACC_NV ? NV_WORD0 : s_q.cfg0;
        end else if (ACC_SEL == `OCT_SEL_CFG1) begin
          s_d.rdata = ACC_NV ? NV_WORD1 : s_q.cfg1;
        end else begin
          s_d.rdata = '0;
        end
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (s_q.phase != oct_pkg::PH_RUN || trip_dis[i]) begin
        s_d.qual_cnt[i] = 8'h00;
        s_d.clr_cnt[i] = 4'h0;
        s_d.oc_act[i] = 1'b0;
      end else if (!s_q.oc_act[i]) begin
        s_d.clr_cnt[i] = 4'h0;
        // any dip below trip restarts the qualifier
        if (!above[i]) begin
          s_d.qual_cnt[i] = 8'h00;
        end else if (s_q.qual_cnt[i] >= qual_cyc - 8'h01) begin
          s_d.oc_act[i] = 1'b1;
          s_d.qual_cnt[i] = 8'h00;
        end else begin
          s_d.qual_cnt[i] = s_q.qual_cnt[i] + 8'h01;
        end
      end else if (!below_rel[i]) begin
        s_d.clr_cnt[i] = 4'h0;
      end else if (8'(s_q.clr_cnt[i]) >= CLR_CYC - 8'h01) begin
        s_d.oc_act[i] = 1'b0;
        s_d.clr_cnt[i] = 4'h0;
      end else begin
        s_d.clr_cnt[i] = s_q.clr_cnt[i] + 4'h1;
      end
    end
    if (trip_hold && (|s_d.oc_act || OT_DETECT)) begin
      s_d.hold = 1'b1;
    end
    s_d.fault_n = ~(|s_d.oc_act | OT_DETECT | s_d.hold);
    // trims are sign extended so downstream adds treat them as signed
    s_d.gain = {{3{s_d.cfg0[`OCT_GAIN_MSB]}},
                s_d.cfg0[`OCT_GAIN_MSB:`OCT_GAIN_LSB]};
    s_d.zero = {{3{s_d.cfg0[`OCT_ZERO_MSB]}},
                s_d.cfg0[`OCT_ZERO_MSB:`OCT_ZERO_LSB]};
    s_d.sense_inv = ~s_d.cfg0[`OCT_POL_BIT];
    if (TEMP_SAMPLE_VALID) begin
      s_d.temp = TEMP_SAMPLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.cfg0 <= `OCT_CFG0_RST;
      s_q.cfg1 <= `OCT_CFG1_RST;
      s_q.fault_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign ACC_ACK = s_q.ack;
  assign ACC_REFUSE = s_q.refuse;
  assign ACC_RDATA = s_q.rdata;
  assign NV_WR_STB = s_q.nv_stb;
  assign NV_WR_SEL = s_q.nv_sel;
  assign NV_WR_DATA = s_q.nv_data;
  assign GAIN_TRIM = s_q.gain;
  assign ZERO_LEVEL_TRIM = s_q.zero;
  assign OUTPUT_SENSE_INVERT = s_q.sense_inv;
  assign FAULT_N = s_q.fault_n;
  assign OC_POS_ACTIVE = s_q.oc_act[0];
  assign OC_NEG_ACTIVE = s_q.oc_act[1];
  assign TEMP_CODE = s_q.temp;
  assign READY = (s_q.phase == oct_pkg::PH_RUN);

  // helper: consecutive cycles of enabled positive excursion above trip
  logic [8:0] run_q;
  always_ff @(posedge CLK) begin
    if (RST || !above[0] || trip_dis[0] || !READY) begin
      run_q <= 9'h000;
    end else if (run_q != 9'h1FF) begin
      run_q <= run_q + 9'h001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_nv_write_lock: assert property (
    READY && ACC_REQ && ACC_WRITE && ACC_NV && wlock |=> ACC_REFUSE && !NV_WR_STB)
    else $error("eeprom write passed while locked");
  a_read_kept: assert property (
    READY && ACC_REQ && !ACC_WRITE && path_ok |=> ACC_ACK && !ACC_REFUSE)
    else $error("read refused on open path");
  a_comm_block: assert property (
    READY && ACC_REQ && ACC_VIA_OUT && comm_block |=> ACC_REFUSE && !ACC_ACK)
    else $error("output pin access taken while blocked");
  a_trim_sign: assert property (
    GAIN_TRIM[11:9] == {3{GAIN_TRIM[8]}} && ZERO_LEVEL_TRIM[11:9] == {3{ZERO_LEVEL_TRIM[8]}})
    else $error("trim not sign extended");
  a_pol_reset: assert property (@(posedge CLK) disable iff (1'b0)
    RST |=> !OUTPUT_SENSE_INVERT && FAULT_N)
    else $error("polarity or fault wrong after reset");
  a_pos_disable: assert property (
    trip_dis[0] && $past(trip_dis[0]) |-> !OC_POS_ACTIVE)
    else $error("positive trip while disabled");
  a_neg_disable: assert property (
    trip_dis[1] |=> !OC_NEG_ACTIVE)
    else $error("negative trip while disabled");
  a_neg_unidir: assert property (
    READY && !s_q.bidir |-> !OC_NEG_ACTIVE)
    else $error("negative trip on unidirectional part");
  a_hold_low: assert property (
    trip_hold && !FAULT_N |=> !FAULT_N)
    else $error("held fault released");
  a_qual_short: assert property (
    $rose(OC_POS_ACTIVE) |-> $past(above[0], 1) && $past(above[0], 23))
    else $error("positive trip before qualifier delay");
  a_qual_short_neg: assert property (
    $rose(OC_NEG_ACTIVE) |-> $past(above[1], 1) && $past(above[1], 23))
    else $error("negative trip before qualifier delay");
  a_qual_long: assert property (
    run_q > 9'h0B3 |-> OC_POS_ACTIVE)
    else $error("positive trip missing after longest qualifier");
  a_release_clear: assert property (
    OC_POS_ACTIVE && !trip_dis[0] && !below_rel[0] |=> OC_POS_ACTIVE)
    else $error("release before hysteresis condition");
  a_release_delay: assert property (
    $fell(OC_POS_ACTIVE) && !$past(trip_dis[0]) && !$past(RST)
    |-> $past(below_rel[0], 1) && $past(below_rel[0], 10))
    else $error("release before fault clear time");
  a_hyst_clamp: assert property (
    hyst_eff[0] + `OCT_HYST_FLOOR <= trip_lvl[0] && hyst_eff[0] <= hyst_raw)
    else $error("hysteresis above clamp");
  a_fault_idle: assert property (
    !FAULT_N |-> OC_POS_ACTIVE || OC_NEG_ACTIVE || s_q.hold || $past(OT_DETECT))
    else $error("fault low without cause");
  a_temp_read: assert property (
    TEMP_SAMPLE_VALID |=> TEMP_CODE == $past(TEMP_SAMPLE))
    else $error("temperature not captured");
  a_shadow_load: assert property (
    s_q.phase == oct_pkg::PH_LOAD |=> s_q.cfg0 == $past(NV_WORD0) && READY)
    else $error("shadow not loaded at startup");

  c_pos_trip: cover property ($rose(OC_POS_ACTIVE));
  c_pos_release: cover property ($fell(OC_POS_ACTIVE) && FAULT_N);
  c_neg_trip: cover property ($rose(OC_NEG_ACTIVE));
  c_lock_refuse: cover property (ACC_REFUSE && wlock);
  c_held_fault: cover property (s_q.hold && !FAULT_N ##5 !FAULT_N);
endmodule : oct_fault_trim
`default_nettype wire

/* logic/oct_pkg.sv */
// Purpose: types for the overcurrent fault and trim logic
// Assumes: oct_consts.svh supplies the widths
// Notes: whole module state except the run_q assertion counter is one struct
`include "oct_consts.svh"
package oct_pkg;
  typedef enum logic {PH_LOAD, PH_RUN} oct_phase_t;
  typedef struct packed {
    oct_phase_t phase;
    logic bidir;
    logic [`OCT_WORD_W-1:0] cfg0;
    logic [`OCT_WORD_W-1:0] cfg1;
    logic [1:0][7:0] qual_cnt;
    logic [1:0][3:0] clr_cnt;
    logic [1:0] oc_act;
    logic hold;
    logic fault_n;
    logic ack;
    logic refuse;
    logic [`OCT_WORD_W-1:0] rdata;
    logic nv_stb;
    logic nv_sel;
    logic [`OCT_WORD_W-1:0] nv_data;
    logic [11:0] gain;
    logic [11:0] zero;
    logic [11:0] temp;
    logic sense_inv;
  } oct_state_t;
endpackage : oct_pkg
